/* pkg/uei_consts.svh */
/*
 * Register offsets, field positions, reset values and counts of the
 * USB error interrupt logic.
 * Assumes byte addressing on a 32-bit APB with one aligned word per register.
 */
`ifndef UEI_CONSTS_SVH
`define UEI_CONSTS_SVH

`define UEI_ADDR_STATUS     8'h00
`define UEI_ADDR_ENABLE     8'h04
`define UEI_ADDR_IRQ_EN     8'h08
`define UEI_ADDR_IRQ_FLAG   8'h0c

`define UEI_BIT_BIT_STUFF   7
`define UEI_BIT_BUS_MATRIX  6
`define UEI_BIT_MEM_ACCESS  5
`define UEI_BIT_TURNAROUND  4
`define UEI_BIT_FIELD_SIZE  3
`define UEI_BIT_DATA_CRC    2
`define UEI_BIT_TOKEN_EOF   1
`define UEI_BIT_PID         0
`define UEI_BIT_COMBINED    1

`define UEI_ERR_W           8
`define UEI_ENABLE_RST      8'h00
`define UEI_STATUS_RST      8'h00
`define UEI_IRQ_EN_RST      1'b0
`define UEI_BTO_BITS        5'h10

`endif

/* pkg/uei_pkg.sv */
/*
 * Types shared by the USB error interrupt logic.
 * Assumes uei_consts.svh is compiled with it.
 */
`include "uei_consts.svh"

package uei_pkg;

    typedef logic [`UEI_ERR_W-1:0] uei_err_vec_t;

    typedef enum logic [1:0] {
        UEI_BTO_IDLE = 2'b01,
        UEI_BTO_WAIT = 2'b10
    } uei_bto_state_t;

endpackage : uei_pkg

/* pkg/uei_err_if.sv */
/*
 * Carrier between the register block and the bus timing watcher.
 * Assumes both ends share one clock; all signals are same-domain pulses or levels.
 */
`timescale 1ns/1ns

interface uei_err_if;
    logic eop;
    logic resp_start;
    logic bit_tick;
    logic sof_zero;
    logic xfer_busy;
    logic bto_evt;
    logic eof_evt;

    modport regs  (output eop, resp_start, bit_tick, sof_zero, xfer_busy,
                   input  bto_evt, eof_evt);
    modport timer (input  eop, resp_start, bit_tick, sof_zero, xfer_busy,
                   output bto_evt, eof_evt);
endinterface : uei_err_if

/* src/uei_bus_timer.sv */
/*
 * Bus timing watcher: turnaround time-out after end-of-packet and
 * end-of-frame detection from the start-of-frame down-counter.
 * Assumes a one-cycle bit_tick per bit time from the USB engine and an
 * asynchronous active-low reset already released through flip-flops.
 */
`timescale 1ns/1ns

module uei_bus_timer
    import uei_pkg::*;
(
    // Clock, reset, enable
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    // Engine events and results
    uei_err_if.timer  bus
);

    uei_bto_state_t state_reg;
    logic [4:0]     bits_reg;
    logic           bto_reg;
    logic           eof_reg;
    logic           eof_cond_reg;
    logic           eof_cond;

    assign eof_cond    = bus.sof_zero && bus.xfer_busy;
    assign bus.bto_evt = bto_reg;
    assign bus.eof_evt = eof_reg;

    // Waits for the answer; a tick past the sixteenth idle bit is a time-out
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= UEI_BTO_IDLE;
            bits_reg  <= 5'h00;
            bto_reg   <= 1'b0;
        end else if (ce_i) begin
            bto_reg <= 1'b0;
            unique case (state_reg)
                UEI_BTO_IDLE: begin
                    if (bus.eop) begin
                        state_reg <= UEI_BTO_WAIT;
                        bits_reg  <= 5'h00;
                    end
                end
                UEI_BTO_WAIT: begin
                    if (bus.resp_start) begin
                        state_reg <= UEI_BTO_IDLE;
                    end else if (bus.bit_tick) begin
                        if (bits_reg == `UEI_BTO_BITS) begin
                            bto_reg   <= 1'b1;
                            state_reg <= UEI_BTO_IDLE;
                        end else begin
                            bits_reg <= bits_reg + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // One pulse per counter underflow during traffic, not one per cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eof_cond_reg <= 1'b0;
            eof_reg      <= 1'b0;
        end else if (ce_i) begin
            eof_cond_reg <= eof_cond;
            eof_reg      <= eof_cond && !eof_cond_reg;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    bto_after_sixteen_a: assert property (
        ce_i && state_reg == UEI_BTO_WAIT && !bus.resp_start && bus.bit_tick
        && bits_reg == `UEI_BTO_BITS |=> bus.bto_evt && state_reg == UEI_BTO_IDLE)
        else $error("turnaround time-out not raised after sixteen idle bits");

    bto_not_early_a: assert property (
        bus.bto_evt |-> $past(bits_reg) == `UEI_BTO_BITS)
        else $error("turnaround time-out raised too early");

    eof_detect_a: assert property (
        ce_i && eof_cond && !eof_cond_reg |=> bus.eof_evt)
        else $error("end-of-frame condition missed");

endmodule : uei_bus_timer

/* src/uei_top.sv */
/*
 * USB error interrupt logic: sticky error status, error enable mask,
 * combined error interrupt and its enable, all on an APB slave.
 * Assumes error inputs are one-cycle pulses or levels from USB engine logic
 * on the same clock, and host_mode_i selects host or device meaning.
 */
// The APB interface to the registers and the address map were decided locally.
// What this block does
// - In device mode, flag bit 1 sets on a rejected token with CRC5 error.
// - In host mode, flag bit 1 is the end-of-frame error flag.
// - End-of-frame error: SOF down-counter hits zero during transfer.
// - Flag bit 0 sets when a received packet identifier fails its check.
// - Memory access error on late bus grant or truncated receive packet.
// - Turnaround time-out after more than 16 idle bit times past end-of-packet.
// - Enable bits 7..4: bit stuff, bus matrix, memory access, turnaround.
// - Enable bits 3, 2, 0: field size, data CRC, packet identifier.
// - Enable bit 1 follows mode: token CRC or end-of-frame.
// - Enable one lets its flag request an interrupt; zero blocks it.
// - Enabled errors reach the module interrupt only with combined enable set.
// - Enable register bits 31..8 read zero.
// - Combined error flag is set only by enabled error conditions.
`timescale 1ns/1ns

module uei_top
    import uei_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // USB engine error reports
    input  wire logic        host_mode_i,
    input  wire logic        pid_err_i,
    input  wire logic        token_crc_err_i,
    input  wire logic        data_crc_err_i,
    input  wire logic        field_size_err_i,
    input  wire logic        bit_stuff_err_i,
    input  wire logic        bus_matrix_err_i,
    input  wire logic        dma_grant_late_i,
    input  wire logic        rx_truncated_i,
    // USB engine bus timing
    input  wire logic        eop_i,
    input  wire logic        resp_start_i,
    input  wire logic        bit_tick_i,
    input  wire logic        sof_zero_i,
    input  wire logic        xfer_busy_i,
    // Interrupt
    output logic             module_irq_flag_o
);

    logic [1:0]   rst_sync_reg;
    logic         rst_n;
    uei_err_vec_t usb_error_status;
    uei_err_vec_t usb_error_status_next;
    uei_err_vec_t usb_error_enable;
    logic         combined_error_irq_en;
    logic         combined_error_irq_flag;
    uei_err_vec_t err_set;
    uei_err_vec_t err_clr;
    logic [31:0]  prdata_reg;
    logic         rd_ready_reg;
    logic         wr_en;
    logic         rd_load;

    uei_err_if err_bus ();

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == `UEI_ADDR_STATUS) || (a == `UEI_ADDR_ENABLE)
                  || (a == `UEI_ADDR_IRQ_EN) || (a == `UEI_ADDR_IRQ_FLAG);
    endfunction : addr_known

    function automatic logic wr_hits(input logic [7:0] a);
        wr_hits = wr_en && (paddr_i == a) && pstrb_i[0];
    endfunction : wr_hits

    // Reset enters asynchronously, leaves synchronously; runs regardless of ce_i
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign err_bus.eop        = eop_i;
    assign err_bus.resp_start = resp_start_i;
    assign err_bus.bit_tick   = bit_tick_i;
    assign err_bus.sof_zero   = sof_zero_i;
    assign err_bus.xfer_busy  = xfer_busy_i;

    uei_bus_timer u_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .bus     (err_bus)
    );

    // Error events this cycle
    always_comb begin
        err_set                      = '0;
        err_set[`UEI_BIT_BIT_STUFF]  = bit_stuff_err_i;
        err_set[`UEI_BIT_BUS_MATRIX] = bus_matrix_err_i;
        err_set[`UEI_BIT_MEM_ACCESS] = dma_grant_late_i || rx_truncated_i;
        err_set[`UEI_BIT_TURNAROUND] = err_bus.bto_evt;
        err_set[`UEI_BIT_FIELD_SIZE] = field_size_err_i;
        err_set[`UEI_BIT_DATA_CRC]   = data_crc_err_i;
        // Shared position, meaning picked by the active mode
        err_set[`UEI_BIT_TOKEN_EOF]  = host_mode_i ? err_bus.eof_evt
                                                   : token_crc_err_i;
        err_set[`UEI_BIT_PID]        = pid_err_i;
    end

    // APB: zero wait states once read data has been captured
    assign wr_en     = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_load   = psel_i && ce_i;
    assign pready_o  = ce_i && rd_ready_reg;
    assign pslverr_o = psel_i && penable_i && pready_o && !addr_known(paddr_i);
    assign prdata_o  = prdata_reg;

    assign err_clr = wr_hits(`UEI_ADDR_STATUS) ? pwdata_i[`UEI_ERR_W-1:0] : '0;

    // A new event in the clearing cycle survives the clear
    assign usb_error_status_next = (usb_error_status & ~err_clr) | err_set;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            usb_error_status <= `UEI_STATUS_RST;
        end else if (ce_i) begin
            usb_error_status <= usb_error_status_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            usb_error_enable <= `UEI_ENABLE_RST;
        end else if (ce_i && wr_hits(`UEI_ADDR_ENABLE)) begin
            usb_error_enable <= pwdata_i[`UEI_ERR_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            combined_error_irq_en <= `UEI_IRQ_EN_RST;
        end else if (ce_i && wr_hits(`UEI_ADDR_IRQ_EN)) begin
            combined_error_irq_en <= pwdata_i[`UEI_BIT_COMBINED];
        end
    end

    // Bit 1 enable covers whichever meaning bit 1 of the status carries now
    assign combined_error_irq_flag = |(usb_error_status & usb_error_enable);
    assign module_irq_flag_o = combined_error_irq_flag && combined_error_irq_en;

    // Read data is captured a cycle ahead so it comes from a flip-flop
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg   <= 32'h0000_0000;
            rd_ready_reg <= 1'b0;
        end else begin
            rd_ready_reg <= rd_load;
            if (rd_load) begin
                prdata_reg <= 32'h0000_0000;
                unique case (paddr_i)
                    `UEI_ADDR_STATUS:   prdata_reg[`UEI_ERR_W-1:0] <= usb_error_status;
                    `UEI_ADDR_ENABLE:   prdata_reg[`UEI_ERR_W-1:0] <= usb_error_enable;
                    `UEI_ADDR_IRQ_EN:   prdata_reg[`UEI_BIT_COMBINED] <= combined_error_irq_en;
                    `UEI_ADDR_IRQ_FLAG: prdata_reg[`UEI_BIT_COMBINED] <= combined_error_irq_flag;
                    default:            prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence seq_enable_cleared;
        ce_i && wr_hits(`UEI_ADDR_ENABLE) && pwdata_i[`UEI_ERR_W-1:0] == 8'h00;
    endsequence

    sequence seq_no_enable_write;
        !(ce_i && wr_hits(`UEI_ADDR_ENABLE)) && !(ce_i && wr_hits(`UEI_ADDR_IRQ_EN));
    endsequence

    sequence seq_enabled_pid_error;
        ce_i && pid_err_i && usb_error_enable[`UEI_BIT_PID] && combined_error_irq_en;
    endsequence

    pid_flag_set_a: assert property (
        ce_i && pid_err_i |=> usb_error_status[`UEI_BIT_PID])
        else $error("packet identifier failure not flagged");

    token_crc_dev_a: assert property (
        ce_i && !host_mode_i && token_crc_err_i |=> usb_error_status[`UEI_BIT_TOKEN_EOF])
        else $error("token CRC error not flagged in device mode");

    eof_flag_host_a: assert property (
        ce_i && host_mode_i && err_bus.eof_evt |=> usb_error_status[`UEI_BIT_TOKEN_EOF])
        else $error("end-of-frame error not flagged in host mode");

    token_crc_host_a: assert property (
        ce_i && host_mode_i && token_crc_err_i && !err_bus.eof_evt
        && !usb_error_status[`UEI_BIT_TOKEN_EOF] |=> !usb_error_status[`UEI_BIT_TOKEN_EOF])
        else $error("token CRC error flagged in host mode");

    mem_access_flag_a: assert property (
        ce_i && (dma_grant_late_i || rx_truncated_i) |=> usb_error_status[`UEI_BIT_MEM_ACCESS])
        else $error("memory access error not flagged");

    turnaround_flag_a: assert property (
        ce_i && err_bus.bto_evt |=> usb_error_status[`UEI_BIT_TURNAROUND])
        else $error("turnaround time-out not flagged");

    sticky_flags_a: assert property (
        ce_i && !wr_hits(`UEI_ADDR_STATUS) |=>
            (usb_error_status & $past(usb_error_status)) == $past(usb_error_status))
        else $error("error flag dropped without a clear");

    enable_readback_a: assert property (
        psel_i && !penable_i && ce_i && paddr_i == `UEI_ADDR_ENABLE ##1 seq_no_enable_write
        |-> prdata_o[31:8] == 24'h00_0000 && prdata_o[7:0] == usb_error_enable)
        else $error("error enable read back wrong");

    enable_reset_a: assert property (
        $rose(rst_n) |-> usb_error_enable == 8'h00 && !module_irq_flag_o)
        else $error("enable bits not zero after reset");

    enabled_irq_a: assert property (
        seq_enabled_pid_error and seq_no_enable_write |=> module_irq_flag_o)
        else $error("enabled error did not raise the interrupt");

    masked_irq_a: assert property (
        seq_enable_cleared |=> !module_irq_flag_o [*2] or !ce_i [*1])
        else $error("interrupt raised with every enable clear");

    combined_gate_a: assert property (
        ce_i && wr_hits(`UEI_ADDR_IRQ_EN) && !pwdata_i[`UEI_BIT_COMBINED] |=> !module_irq_flag_o)
        else $error("interrupt raised with combined enable clear");

endmodule : uei_top

/* sim/uei_usb_model.sv */
/*
 * Stand-in for the USB engine that feeds the error logic: error reports
 * and bus timing events, driven through tasks.
 * Assumes callers enter its tasks just after a rising edge of clk_i.
 */
`timescale 1ns/1ns

module uei_usb_model (
    // Clock
    input  wire logic       clk_i,
    // Error reports: pid, token crc, data crc, size, stuff, matrix, grant, trunc
    output logic      [7:0] err_o,
    // Bus timing
    output logic            eop_o,
    output logic            resp_o,
    output logic            tick_o,
    output logic            sof_zero_o,
    output logic            busy_o
);
    initial begin
        {err_o, eop_o, resp_o, tick_o} = 11'h000;
        sof_zero_o = 1'b0;
        busy_o     = 1'b0;
    end

    // One-cycle event, then one idle cycle so pulses never merge
    task automatic strobe(input logic [10:0] v);
        {err_o, eop_o, resp_o, tick_o} <= v;
        @(posedge clk_i);
        {err_o, eop_o, resp_o, tick_o} <= 11'h000;
        @(posedge clk_i);
    endtask : strobe

    task automatic frame(input logic z, input logic b);
        sof_zero_o <= z;
        busy_o     <= b;
        @(posedge clk_i);
    endtask : frame
endmodule : uei_usb_model

/* sim/tb.sv */
/*
 * Self-checking bench for uei_top: register access, sticky error flags,
 * interrupt gating with random masks, turnaround and end-of-frame errors.
 * Assumes the package, interface, design and uei_usb_model compile first.
 */
`timescale 1ns/1ns
`include "uei_consts.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb;
    import uei_pkg::*;

    logic         clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic         host_mode, irq, eop, resp, tick, sof_zero, busy, se, ie, ce, rdy;
    logic  [7:0]  paddr, err;
    logic  [31:0] pwdata, prdata, rd, d;
    logic  [3:0]  pstrb;
    uei_err_vec_t en, ex;
    int           failures, total_checks, idx;

    uei_top uei_top_inst (.clk_i(clk), .resetn_i(resetn), .ce_i(ce),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .host_mode_i(host_mode), .pid_err_i(err[0]),
        .token_crc_err_i(err[1]), .data_crc_err_i(err[2]), .field_size_err_i(err[3]),
        .bit_stuff_err_i(err[4]), .bus_matrix_err_i(err[5]),
        .dma_grant_late_i(err[6]), .rx_truncated_i(err[7]), .eop_i(eop),
        .resp_start_i(resp), .bit_tick_i(tick), .sof_zero_i(sof_zero),
        .xfer_busy_i(busy), .module_irq_flag_o(irq));

    uei_usb_model uei_usb_model_inst (.clk_i(clk), .err_o(err), .eop_o(eop),
        .resp_o(resp), .tick_o(tick), .sof_zero_o(sof_zero), .busy_o(busy));

    // Status bit that each engine error input should set
    function automatic uei_err_vec_t bit_of(input int i);
        int pos[8] = '{0, 1, 2, 3, 7, 6, 5, 5};
        return uei_err_vec_t'(1) << pos[i];
    endfunction : bit_of

    // Waits on pready without assuming a latency; only the watchdog cuts a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                       input logic [3:0] s);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        // Answer is looked at settled, ahead of the edge that samples it
        do begin
            @(negedge clk);
            rdy = pready;
            rd  = prdata;
            se  = pslverr;
            @(posedge clk);
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next call never drives psel twice at once
        @(posedge clk);
    endtask : apb

    task automatic rd_status(input uei_err_vec_t e, input string nm);
        repeat (3) @(posedge clk);
        apb(1'b0, `UEI_ADDR_STATUS, 32'h0, 4'hf);
        `CHK(nm, {24'h0, e}, rd)
        apb(1'b1, `UEI_ADDR_STATUS, 32'hff, 4'hf);
    endtask : rd_status

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end

    initial begin
        {resetn, psel, penable, pwrite, host_mode} = 5'b0;
        ce = 1'b1;
        {paddr, pwdata, pstrb} = 44'h0;
        failures = 0;
        total_checks = 0;
        void'($urandom(32'hf2f7953f));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, `UEI_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("enable reset", 32'h0, rd)
        apb(1'b0, 8'h10, 32'h0, 4'hf);
        `CHK("unmapped error", 1'b1, se)
        // Low byte strobe off: the write must not land
        apb(1'b1, `UEI_ADDR_ENABLE, 32'hff, 4'he);
        apb(1'b0, `UEI_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("strobe ignored", 32'h0, rd)
        for (idx = 0; idx < 8; idx++) begin
            uei_usb_model_inst.strobe({bit_of(idx) == 8'h0 ? 8'h0 : 8'h1 << idx, 3'b000});
            rd_status(bit_of(idx), "error flag");
            rd_status(8'h00, "flag cleared");
        end
        for (int k = 0; k < 24; k++) begin
            d   = $urandom;
            en  = d[7:0];
            ie  = 1'($urandom);
            idx = $urandom_range(7);
            ex  = bit_of(idx);
            apb(1'b1, `UEI_ADDR_ENABLE, d, 4'hf);
            apb(1'b0, `UEI_ADDR_ENABLE, 32'h0, 4'hf);
            `CHK("enable readback", {24'h0, en}, rd)
            apb(1'b1, `UEI_ADDR_IRQ_EN, {30'h0, ie, 1'b0}, 4'hf);
            uei_usb_model_inst.strobe({8'h1 << idx, 3'b000});
            apb(1'b0, `UEI_ADDR_IRQ_FLAG, 32'h0, 4'hf);
            `CHK("combined flag", {30'h0, |(ex & en), 1'b0}, rd)
            `CHK("module irq", (|(ex & en)) & ie, irq)
            apb(1'b1, `UEI_ADDR_STATUS, 32'hff, 4'hf);
            @(posedge clk);
            `CHK("irq after clear", 1'b0, irq)
        end
        // Clock enable low: an error strobe in that window leaves no trace
        apb(1'b1, `UEI_ADDR_ENABLE, 32'hffff_ff01, 4'hf);
        apb(1'b0, `UEI_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("enable upper bits", 32'h1, rd)
        apb(1'b1, `UEI_ADDR_IRQ_EN, 32'h2, 4'hf);
        ce <= 1'b0;
        uei_usb_model_inst.strobe(11'h008);
        ce <= 1'b1;
        rd_status(8'h00, "frozen flag");
        uei_usb_model_inst.strobe(11'h008);
        `CHK("pid irq", 1'b1, irq)
        // Reset in mid-run must drop the enables written above
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("irq after reset", 1'b0, irq)
        apb(1'b0, `UEI_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("enable after reset", 32'h0, rd)
        apb(1'b1, `UEI_ADDR_ENABLE, 32'hffff_ff00, 4'hf);
        apb(1'b0, `UEI_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("enable cleared", 32'h0, rd)
        // Sixteen idle bit times are still legal, the seventeenth is not
        uei_usb_model_inst.strobe(11'h004);
        repeat (16) uei_usb_model_inst.strobe(11'h001);
        rd_status(8'h00, "turnaround at 16");
        uei_usb_model_inst.strobe(11'h001);
        rd_status(8'h10, "turnaround at 17");
        uei_usb_model_inst.strobe(11'h004);
        repeat (5) uei_usb_model_inst.strobe(11'h001);
        uei_usb_model_inst.strobe(11'h002);
        repeat (20) uei_usb_model_inst.strobe(11'h001);
        rd_status(8'h00, "turnaround answered");
        host_mode <= 1'b1;
        uei_usb_model_inst.frame(1'b1, 1'b0);
        // Token CRC report must not touch bit 1 in host mode
        uei_usb_model_inst.strobe(11'h010);
        rd_status(8'h00, "frame end idle");
        uei_usb_model_inst.frame(1'b0, 1'b0);
        apb(1'b1, `UEI_ADDR_ENABLE, 32'h2, 4'hf);
        apb(1'b1, `UEI_ADDR_IRQ_EN, 32'h2, 4'hf);
        uei_usb_model_inst.frame(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        `CHK("end of frame irq", 1'b1, irq)
        rd_status(8'h02, "end of frame flag");
        uei_usb_model_inst.frame(1'b0, 1'b0);
        final_report();
    end
endmodule : tb
